// [agc_gain_limit_config.sv]
// module: gain-control limit and carrier-sense configuration register bank
module agc_gain_limit_config (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       nrst,
    // register port
    input  wire logic [agc_pkg::ADDR_W-1:0] addr,
    input  wire logic [agc_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [agc_pkg::DATA_W-1:0] rdata_ff,
    // fields to gain control
    output logic      [1:0]                 digital_gain_cap,
    output logic      [2:0]                 front_amp_gain_cap,
    output logic      [2:0]                 amplitude_goal,
    output logic                            gain_reduce_order,
    output logic      [1:0]                 relative_sense_threshold,
    output logic      [3:0]                 absolute_sense_threshold,
    // decoded limits for gain control
    output logic      [2:0]                 digital_gain_max_ff,
    output logic                            rel_sense_en_ff,
    output logic                            abs_sense_en_ff
);
    import agc_pkg::*;

    //--------------------------------------------------------------------------
    // overview
    //--------------------------------------------------------------------------
    // two eight-bit registers hold the gain caps, the amplitude goal, the
    // reduction order and both carrier-sense thresholds.
    // every field leaves the bank straight from its own flop, so gain
    // control may sample it on any edge without a glitch from the bus.
    // the decoded limits are registered as well and always agree with the
    // fields they come from on the same edge.
    // the slave never stalls: a write lands on the edge that takes it and
    // read data stand in the next cycle only, zero at all other times.
    // the count of digital gain settings is an assumption; its top index
    // sits in the package so that it can be changed in one place.

    //--------------------------------------------------------------------------
    // address decode
    //--------------------------------------------------------------------------
    // match one register address; only the two mapped words respond,
    // so a write anywhere else in the window leaves every field alone
    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] r
    );
        hit = (a == r);
    endfunction

    // register selects, shared by the write and the read path
    wire logic sel_cap  = hit(addr, ADDR_CAP_TARGET);
    wire logic sel_prio = hit(addr, ADDR_PRIO_SENSE);

    // write enables per register
    wire logic ld_cap   = wr & sel_cap;
    wire logic ld_prio  = wr & sel_prio;

    // read enables per register; strobes never come together
    wire logic rd_cap   = rd & sel_cap;
    wire logic rd_prio  = rd & sel_prio;

    //--------------------------------------------------------------------------
    // write data slices
    //--------------------------------------------------------------------------
    // each field's slice of the write word for storage; the cap, relative and absolute slices also feed the limits;
    // bit seven of the second register has no slice and is dropped
    wire logic [1:0] wd_dg_cap = wdata[DG_CAP_LSB +: 2];
    wire logic [2:0] wd_fa_cap = wdata[FA_CAP_LSB +: 3];
    wire logic [2:0] wd_goal   = wdata[GOAL_LSB +: 3];
    wire logic       wd_order  = wdata[ORDER_BIT];
    wire logic [1:0] wd_rel    = wdata[REL_LSB +: 2];
    wire logic [3:0] wd_abs    = wdata[ABS_LSB +: 4];

    //--------------------------------------------------------------------------
    // field storage
    //--------------------------------------------------------------------------
    // every field holds its value until its register is written, and shows
    // the written value from the edge that takes the write

    // digital gain cap, bits 7:6 of the first register
    agc_cfg_reg #(
        .W   (2),
        .RST (DG_CAP_RST)
    ) u_dg (
        .clock (clock),
        .nrst  (nrst),
        .load  (ld_cap),
        .din   (wd_dg_cap),
        .q_ff  (digital_gain_cap)
    );

    // front amplifier gain cap, bits 5:3 of the first register
    agc_cfg_reg #(
        .W   (3),
        .RST (FA_CAP_RST)
    ) u_fa (
        .clock (clock),
        .nrst  (nrst),
        .load  (ld_cap),
        .din   (wd_fa_cap),
        .q_ff  (front_amp_gain_cap)
    );

    // amplitude goal, bits 2:0 of the first register
    agc_cfg_reg #(
        .W   (3),
        .RST (GOAL_RST)
    ) u_goal (
        .clock (clock),
        .nrst  (nrst),
        .load  (ld_cap),
        .din   (wd_goal),
        .q_ff  (amplitude_goal)
    );

    // reduction order, bit 6 of the second register
    agc_cfg_reg #(
        .W   (1),
        .RST (ORDER_RST)
    ) u_ord (
        .clock (clock),
        .nrst  (nrst),
        .load  (ld_prio),
        .din   (wd_order),
        .q_ff  (gain_reduce_order)
    );

    // relative threshold, bits 5:4 of the second register
    agc_cfg_reg #(
        .W   (2),
        .RST (REL_RST)
    ) u_rel (
        .clock (clock),
        .nrst  (nrst),
        .load  (ld_prio),
        .din   (wd_rel),
        .q_ff  (relative_sense_threshold)
    );

    // absolute threshold, bits 3:0 of the second register
    agc_cfg_reg #(
        .W   (4),
        .RST (ABS_RST)
    ) u_abs (
        .clock (clock),
        .nrst  (nrst),
        .load  (ld_prio),
        .din   (wd_abs),
        .q_ff  (absolute_sense_threshold)
    );

    //--------------------------------------------------------------------------
    // decoded limits
    //--------------------------------------------------------------------------
    // the next value comes from the write data while a write lands, so the
    // limits change on the same edge as the fields they are made from and
    // gain control never sees a field and its limit disagree
    wire logic [1:0] dg_src  = ld_cap ? wd_dg_cap : digital_gain_cap;
    wire logic [1:0] rel_src = ld_prio ? wd_rel : relative_sense_threshold;
    wire logic [3:0] abs_src = ld_prio ? wd_abs : absolute_sense_threshold;

    // highest usable digital gain setting: top index minus the cap, so
    // each cap step bars one more of the top settings
    wire logic [2:0] nxt_dg_max = DG_TOP - {1'b0, dg_src};
    // a threshold is live unless it holds its disable code
    wire logic       nxt_rel_en = (rel_src != REL_OFF);
    wire logic       nxt_abs_en = (abs_src != ABS_OFF);

    // limit flops; their reset values follow from the field reset values

    // digital gain ceiling flop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            digital_gain_max_ff <= DG_TOP - {1'b0, DG_CAP_RST};
        end else begin
            digital_gain_max_ff <= nxt_dg_max;
        end
    end

    // relative sense enable flop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rel_sense_en_ff <= (REL_RST != REL_OFF);
        end else begin
            rel_sense_en_ff <= nxt_rel_en;
        end
    end

    // absolute sense enable flop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            abs_sense_en_ff <= (ABS_RST != ABS_OFF);
        end else begin
            abs_sense_en_ff <= nxt_abs_en;
        end
    end

    //--------------------------------------------------------------------------
    // read path
    //--------------------------------------------------------------------------
    // first register as software sees it
    wire logic [7:0] cap_word  = {digital_gain_cap,
                                  front_amp_gain_cap,
                                  amplitude_goal};
    // second register; the unused top bit always reads zero
    wire logic [7:0] prio_word = {1'b0,
                                  gain_reduce_order,
                                  relative_sense_threshold,
                                  absolute_sense_threshold};
    // data stand only in the cycle after the strobe; an unmapped address
    // or an idle cycle gives zero, so stale data never linger on the bus
    wire logic [7:0] nxt_rdata = rd_cap  ? cap_word  :
                                 rd_prio ? prio_word : 8'h00;

    // read data register, zero between reads
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
endmodule // agc_gain_limit_config

// [agc_pkg.sv]
// package: register map, field layout and reset values for gain-control config
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package agc_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;

    // register addresses
    localparam logic [15:0] ADDR_CAP_TARGET = 16'hdf17;
    localparam logic [15:0] ADDR_PRIO_SENSE = 16'hdf18;

    // field positions, first register
    localparam int unsigned DG_CAP_LSB = 6;
    localparam int unsigned FA_CAP_LSB = 3;
    localparam int unsigned GOAL_LSB   = 0;
    // field positions, second register
    localparam int unsigned ORDER_BIT  = 6;
    localparam int unsigned REL_LSB    = 4;
    localparam int unsigned ABS_LSB    = 0;

    // reset values
    localparam logic [1:0] DG_CAP_RST = 2'h0;
    localparam logic [2:0] FA_CAP_RST = 3'h0;
    localparam logic [2:0] GOAL_RST   = 3'h3;
    localparam logic       ORDER_RST  = 1'h1;
    localparam logic [1:0] REL_RST    = 2'h0;
    localparam logic [3:0] ABS_RST    = 4'h0;

    // codes with special meaning
    localparam logic [3:0] ABS_OFF  = 4'h8;
    localparam logic [1:0] REL_OFF  = 2'h0;
    // highest digital gain setting index (settings 0..top)
    localparam logic [2:0] DG_TOP   = 3'h7;
endpackage : agc_pkg

// [agc_cfg_reg.sv]
// module: one loadable configuration field with reset value
module agc_cfg_reg #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // load
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] q_ff
);
    // field holds value until loaded
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q_ff <= RST;
        end else if (load) begin
            q_ff <= din;
        end
    end
endmodule // agc_cfg_reg

// [agc_cfg_asserts.sv]
// checker: port-level properties of the gain-control config bank
module agc_cfg_asserts
    import agc_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // register port
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata_ff,
    // fields
    input wire logic [1:0]  digital_gain_cap,
    input wire logic [2:0]  front_amp_gain_cap,
    input wire logic [2:0]  amplitude_goal,
    input wire logic        gain_reduce_order,
    input wire logic [1:0]  relative_sense_threshold,
    input wire logic [3:0]  absolute_sense_threshold,
    // decoded limits
    input wire logic [2:0]  digital_gain_max_ff,
    input wire logic        rel_sense_en_ff,
    input wire logic        abs_sense_en_ff
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // register images and address matches rebuilt from the ports
    wire logic [7:0] cap_w   = {digital_gain_cap, front_amp_gain_cap,
                                amplitude_goal};
    wire logic [7:0] pri_w   = {1'b0, gain_reduce_order,
                                relative_sense_threshold,
                                absolute_sense_threshold};
    wire logic       hit_cap = (addr == ADDR_CAP_TARGET);
    wire logic       hit_pri = (addr == ADDR_PRIO_SENSE);
    wire logic       wr_map  = wr && (hit_cap || hit_pri);
    wire logic       rd_map  = rd && (hit_cap || hit_pri);

    // a write lands on the fields one cycle later
    cap_write_a: assert property (wr && hit_cap |=>
        cap_w == $past(wdata))
        else $error("cap register write not applied");
    pri_write_a: assert property (wr && hit_pri |=>
        pri_w == {1'b0, $past(wdata[6:0])})
        else $error("threshold register write not applied");
    // nothing moves without a write to one of the two registers
    field_hold_a: assert property (!wr_map |=>
        $stable({cap_w, pri_w}))
        else $error("fields changed without a write");
    // read data stand in the cycle after the strobe only
    cap_read_a: assert property (rd && hit_cap |=>
        rdata_ff == $past(cap_w))
        else $error("cap register read wrong");
    pri_read_a: assert property (rd && hit_pri |=>
        rdata_ff == $past(pri_w))
        else $error("threshold register read wrong");
    read_idle_a: assert property (!rd_map |=> rdata_ff == 8'h00)
        else $error("read data not zero");
    // decoded limits agree with their fields
    gain_max_a: assert property (
        digital_gain_max_ff == DG_TOP - {1'b0, digital_gain_cap})
        else $error("digital gain ceiling wrong");
    sense_en_a: assert property (
        rel_sense_en_ff == (relative_sense_threshold != REL_OFF) &&
        abs_sense_en_ff == (absolute_sense_threshold != ABS_OFF))
        else $error("sense enables wrong");
    // main scenarios reached
    cover property (wr && hit_pri && wdata[3:0] == ABS_OFF);
    cover property ((wr && hit_cap) ##1 (rd && hit_cap));
    cover property (rd && !hit_cap && !hit_pri);
endmodule // agc_cfg_asserts
bind agc_gain_limit_config agc_cfg_asserts agc_cfg_asserts_inst (
    .clock                    (clock),
    .nrst                     (nrst),
    .addr                     (addr),
    .wdata                    (wdata),
    .wr                       (wr),
    .rd                       (rd),
    .rdata_ff                 (rdata_ff),
    .digital_gain_cap         (digital_gain_cap),
    .front_amp_gain_cap       (front_amp_gain_cap),
    .amplitude_goal           (amplitude_goal),
    .gain_reduce_order        (gain_reduce_order),
    .relative_sense_threshold (relative_sense_threshold),
    .absolute_sense_threshold (absolute_sense_threshold),
    .digital_gain_max_ff      (digital_gain_max_ff),
    .rel_sense_en_ff          (rel_sense_en_ff),
    .abs_sense_en_ff          (abs_sense_en_ff)
);

// [agc_gain_limit_config_tb.sv]
// testbench: random register traffic against a behavioural model
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module agc_gain_limit_config_tb
    import agc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, nrst, wr, rd;
    logic [15:0] addr;
    logic [7:0] wdata, rdata_ff;
    logic [1:0] dcap, rel;
    logic [2:0] fcap, goal, gmax;
    logic [3:0] abs_thr;
    logic order, rel_en, abs_en;
    int n_mismatch = 0, tests_run = 0, cyc = 0, ex = 0;
    // model registers start at the reset values of their fields
    int m0 = {DG_CAP_RST, FA_CAP_RST, GOAL_RST};
    int m1 = {1'b0, ORDER_RST, REL_RST, ABS_RST};
    bit [31:0] s = 30223, r;
    agc_gain_limit_config agc_gain_limit_config_inst (.clock(clock),
        .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_ff(rdata_ff), .digital_gain_cap(dcap),
        .front_amp_gain_cap(fcap), .amplitude_goal(goal),
        .gain_reduce_order(order), .relative_sense_threshold(rel),
        .absolute_sense_threshold(abs_thr), .digital_gain_max_ff(gmax),
        .rel_sense_en_ff(rel_en), .abs_sense_en_ff(abs_en));
    function automatic bit [31:0] xs();
        s ^= s << 13; s ^= s >> 17; s ^= s << 5;
        return s;
    endfunction
    task automatic results;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    // model: read sees old value, bit seven of second register stays zero
    always @(posedge clock) begin
        cyc++;
        ex = 0;
        if (rd && addr == ADDR_CAP_TARGET) ex = m0;
        if (rd && addr == ADDR_PRIO_SENSE) ex = m1;
        if (wr && addr == ADDR_CAP_TARGET) m0 = wdata;
        if (wr && addr == ADDR_PRIO_SENSE) m1 = wdata & 8'h7f;
    end
    // watchdog: a hang counts as a mismatch and ends the run
    always @(posedge clock) begin
        if (cyc == 2000) begin
            n_mismatch++;
            results();
        end
    end
    // compare every field, limit and read result off the edge;
    // nothing is looked at before the first clock edge
    always @(negedge clock) begin
        if (cyc > 0) begin
            `CHK("caps", m0[7:0], {dcap, fcap, goal})
            `CHK("order", m1[6:0], {order, rel, abs_thr})
            `CHK("rdata", ex[7:0], rdata_ff)
            `CHK("gmax", DG_TOP - 3'(m0[7:6]), gmax)
            `CHK("en", {m1[5:4] != REL_OFF, m1[3:0] != ABS_OFF},
                 {rel_en, abs_en})
        end
    end
    // random writes and reads, some to an unmapped address
    initial begin
        addr = 16'h0; wdata = 8'h0; wr = 0; rd = 0; nrst = 0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (800) begin
            @(posedge clock);
            r = xs();
            addr <= r[1:0] == 0 ? 16'hdf19 :
                    (r[2] ? ADDR_CAP_TARGET : ADDR_PRIO_SENSE);
            wdata <= r[15:8];
            wr <= r[4:3] == 2'h1;
            rd <= r[4:3] == 2'h2;
        end
        // let the last request land and its read data be checked
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (2) @(posedge clock);
        results();
    end
endmodule // agc_gain_limit_config_tb
